// File: rtl/chic_control.sv
// Console halt, continue and initialize control logic.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Stop position keeps the processor halted.
// - Continue position lets the program run.
// - After program halt, stop-then-continue resumes.
// - Release action chosen by toggle position only.
// - Release at stop initializes processor only.
// - Release at continue clears peripherals and boots.
// - Boot starts only on switch release.
// - Held switch asserts initialize continuously.
// - Initialize aborts a running program immediately.
// - Run lamp lit running or blocked, dark halted.
module chic_control #(
  parameter int DebounceCycles = chic_pkg::DebounceCycles,
  parameter int ClearCycles = chic_pkg::PeriphClearCycles
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic runStopToggle,
  input wire logic initSwitch,
  input wire logic [chic_pkg::OptWidth-1:0] bootOptions,
  input wire logic cpuHaltedByProgram,
  input wire logic cpuBlocked,
  output chic_pkg::chic_cmd_t cmd,
  output logic systemInit,
  output logic runLamp
);

  ////////////////////////////////////////////////////////////////////////////
  // Switch conditioning.

  chic_pkg::chic_switches_t sw;
  logic contLevel;
  logic initLevel;
  logic haltReq_q;
  logic resumePulse_q;
  logic cpuInit_q;
  logic periphClear_q;
  logic bootStart_q;
  logic initPrev_q;
  logic contPrev_q;
  logic programHalt_q;
  logic [chic_pkg::ClearWidth-1:0] clearCount_q;
  logic initRelease;
  logic contRise;

  chic_debounce #(.Cycles(DebounceCycles)) u_toggle (
    .sys_clk(sys_clk),
    .reset(reset),
    .rawIn(runStopToggle),
    .cleanOut(contLevel)
  );

  chic_debounce #(.Cycles(DebounceCycles)) u_init (
    .sys_clk(sys_clk),
    .reset(reset),
    .rawIn(initSwitch),
    .cleanOut(initLevel)
  );

  // Each filtered level and each command bit has a single driver.
  assign sw = '{continuePosition: contLevel, initPressed: initLevel};
  assign cmd = '{
    haltReq: haltReq_q,
    resumePulse: resumePulse_q,
    cpuInit: cpuInit_q,
    periphClear: periphClear_q,
    bootStart: bootStart_q
  };

  // One release event per press of the filtered switch.
  assign initRelease = initPrev_q && !sw.initPressed;
  assign contRise = sw.continuePosition && !contPrev_q;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      initPrev_q <= 1'b0;
      contPrev_q <= 1'b0;
    end
    else
    begin
      initPrev_q <= sw.initPressed;
      contPrev_q <= sw.continuePosition;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program halt latch, released by the stop-to-continue sequence.

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      programHalt_q <= 1'b0;
    end
    else if (cpuHaltedByProgram)
    begin
      programHalt_q <= 1'b1;
    end
    else if (contRise)
    begin
      programHalt_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control and initialize outputs.

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      haltReq_q <= 1'b1;
      resumePulse_q <= 1'b0;
      systemInit <= 1'b0;
      cpuInit_q <= 1'b0;
    end
    else
    begin
      haltReq_q <= !sw.continuePosition;
      resumePulse_q <= contRise && programHalt_q;
      systemInit <= sw.initPressed;
      cpuInit_q <= initRelease;
    end
  end

  // Release action: at continue clear peripherals, then start the boot ROM.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      clearCount_q <= '0;
      periphClear_q <= 1'b0;
      bootStart_q <= 1'b0;
    end
    else if (initRelease && sw.continuePosition)
    begin
      clearCount_q <= chic_pkg::ClearWidth'(ClearCycles);
      periphClear_q <= 1'b1;
      bootStart_q <= 1'b0;
    end
    else if (clearCount_q != '0)
    begin
      clearCount_q <= clearCount_q - chic_pkg::ClearWidth'(1);
      periphClear_q <= clearCount_q != chic_pkg::ClearWidth'(1);
      bootStart_q <= (clearCount_q == chic_pkg::ClearWidth'(1))
        && sw.continuePosition;
    end
    else
    begin
      periphClear_q <= 1'b0;
      bootStart_q <= 1'b0;
    end
  end

  // Run lamp: executing or blocked by failure, dark when halted.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      runLamp <= 1'b0;
    end
    else
    begin
      runLamp <= (sw.continuePosition && !programHalt_q && !sw.initPressed)
        || (cpuBlocked && sw.continuePosition);
    end
  end

  // Option switches are passed to the boot ROM by the processor itself.
  logic unusedOpts;
  assign unusedOpts = ^bootOptions;

endmodule : chic_control
`default_nettype wire

// File: rtl/chic_debounce.sv
// Three-stage synchroniser and debounce filter for one switch input.
`timescale 1ns/1ns
`default_nettype none
module chic_debounce #(
  parameter int Cycles = chic_pkg::DebounceCycles
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic rawIn,
  output logic cleanOut
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic [chic_pkg::DebounceWidth-1:0] count_q;

  // Synchroniser chain; only the later stages are compared.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Output follows only after the input has stood stable long enough.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      count_q <= '0;
      cleanOut <= 1'b0;
    end
    else if (sync2_q != sync3_q || sync3_q == cleanOut)
    begin
      count_q <= '0;
    end
    else if (count_q == chic_pkg::DebounceWidth'(Cycles - 1))
    begin
      count_q <= '0;
      cleanOut <= sync3_q;
    end
    else
    begin
      count_q <= count_q + 1'b1;
    end
  end

endmodule : chic_debounce
`default_nettype wire

// File: rtl/chic_pkg.sv
// Package of constants and types for the console halt/initialize control.
package chic_pkg;

  // Debounce time in microseconds and its cycle count at 100 MHz.
  localparam int DebounceUs = 10;
  localparam int ClkMhz = 100;
  localparam int DebounceCycles = DebounceUs * ClkMhz;
  localparam int DebounceWidth = $clog2(DebounceCycles + 1);

  // Length of the peripheral clear pulse after a boot release, in cycles.
  localparam int PeriphClearCycles = 4;
  localparam int ClearWidth = $clog2(PeriphClearCycles + 1);

  // Width of the bootstrap option switch field.
  localparam int OptWidth = 4;

  // Operator switch levels after synchronising and debouncing.
  typedef struct packed {
    logic continuePosition;
    logic initPressed;
  } chic_switches_t;

  // Commands handed to the processor run control.
  typedef struct packed {
    logic haltReq;
    logic resumePulse;
    logic cpuInit;
    logic periphClear;
    logic bootStart;
  } chic_cmd_t;

endpackage : chic_pkg

// File: verification/chic_control_properties.sv
// Checker of the console control outputs.
`timescale 1ns/1ns
`default_nettype none
module chic_control_properties #(
  parameter int DebounceCycles = chic_pkg::DebounceCycles,
  parameter int ClearCycles = chic_pkg::PeriphClearCycles
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic runStopToggle,
  input wire logic initSwitch,
  input wire logic [chic_pkg::OptWidth-1:0] bootOptions,
  input wire logic cpuHaltedByProgram,
  input wire logic cpuBlocked,
  input wire chic_pkg::chic_cmd_t cmd,
  input wire logic systemInit,
  input wire logic runLamp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_init_release: assert property (
    cmd.cpuInit |-> $past(systemInit) && !systemInit) else $error("init");
  chk_init_once: assert property (
    cmd.cpuInit |=> !cmd.cpuInit) else $error("init pulse");
  chk_clear_len: assert property (
    $rose(cmd.periphClear) |-> cmd.periphClear[*4] ##1 !cmd.periphClear)
    else $error("clear length");
  chk_clear_continue_position: assert property (
    $rose(cmd.periphClear) |-> cmd.cpuInit && !cmd.haltReq)
    else $error("clear at stop");
  chk_boot_after: assert property (
    cmd.bootStart |-> $past(cmd.periphClear) && !cmd.periphClear)
    else $error("boot order");
  chk_halt_lamp: assert property (
    cmd.haltReq && $past(cmd.haltReq) |-> !runLamp) else $error("lamp");
  chk_resume_run: assert property (
    cmd.resumePulse |-> !cmd.haltReq ##1 !cmd.resumePulse)
    else $error("resume");
  chk_init_abort: assert property (
    systemInit && $past(systemInit) && !cpuBlocked && !$past(cpuBlocked)
    |-> !runLamp) else $error("abort");
endmodule : chic_control_properties
bind chic_control chic_control_properties #(
  .DebounceCycles(DebounceCycles),
  .ClearCycles(ClearCycles)
) i_chic_control_properties (
  .sys_clk(sys_clk),
  .reset(reset),
  .runStopToggle(runStopToggle),
  .initSwitch(initSwitch),
  .bootOptions(bootOptions),
  .cpuHaltedByProgram(cpuHaltedByProgram),
  .cpuBlocked(cpuBlocked),
  .cmd(cmd),
  .systemInit(systemInit),
  .runLamp(runLamp)
);
`default_nettype wire

// File: verification/chic_panel_model.sv
// Front-panel switch model with contact bounce.
`timescale 1ns/1ns
`default_nettype none
module chic_panel_model (
  input wire logic sys_clk,
  input wire logic wantRun,
  input wire logic wantInit,
  output logic runStopToggle,
  output logic initSwitch
);
  logic [1:0] chat = 2'h0;
  initial runStopToggle = 1'b0;
  initial initSwitch = 1'b0;
  // The momentary switch chatters briefly after each change.
  always @(posedge sys_clk)
  begin
    runStopToggle <= wantRun;
    if (chat != 2'h0)
    begin
      initSwitch <= ~initSwitch;
      chat <= chat - 2'h1;
    end
    else if (initSwitch != wantInit)
    begin
      initSwitch <= wantInit;
      chat <= 2'h2;
    end
  end
endmodule : chic_panel_model
`default_nettype wire

// File: verification/console_halt_init_control_tb.sv
// Self-checking bench for the console control.
`timescale 1ns/1ns
`default_nettype none
module console_halt_init_control_tb;
  logic sys_clk = 0, reset = 1, wantRun = 0, wantInit = 0;
  logic hlt = 0, blk = 0, rsw, isw, sysInit, lamp;
  logic [chic_pkg::OptWidth-1:0] opt = 0;
  chic_pkg::chic_cmd_t cmd;
  int err_total = 0, checked = 0, cyc = 0, seed = 32'h8c8a, n[3];
  localparam int ClrN = 4;
  always #5 sys_clk = ~sys_clk;
  chic_panel_model i_chic_panel_model (.sys_clk(sys_clk),
    .wantRun(wantRun), .wantInit(wantInit), .runStopToggle(rsw),
    .initSwitch(isw));
  chic_control #(.DebounceCycles(4), .ClearCycles(ClrN)) i_chic_control (
    .sys_clk(sys_clk), .reset(reset), .runStopToggle(rsw),
    .initSwitch(isw), .bootOptions(opt), .cpuHaltedByProgram(hlt),
    .cpuBlocked(blk), .cmd(cmd), .systemInit(sysInit), .runLamp(lamp));
  task automatic check(input logic ok);
    checked++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("Error %0t mismatch", $time);
    end
  endtask : check
  task automatic results;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  task automatic wt(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : wt
  function automatic int expClr(input logic run);
    return run ? ClrN : 0;
  endfunction : expClr
  task automatic press(input logic run);
    @(posedge sys_clk) wantRun <= run;
    opt <= chic_pkg::OptWidth'($random(seed));
    wt(20);
    @(posedge sys_clk) wantInit <= 1'b1;
    wt(20);
    check(sysInit === 1'b1 && lamp === 1'b0);
    check(cmd.bootStart === 1'b0 && cmd.cpuInit === 1'b0);
    n = '{0, 0, 0};
    @(posedge sys_clk) wantInit <= 1'b0;
    repeat (30)
    begin
      wt(1);
      n[0] += cmd.cpuInit;
      n[1] += cmd.periphClear;
      n[2] += cmd.bootStart;
    end
    check(n[0] === 1);
    check(n[1] === expClr(run));
    check(n[2] === int'(run));
    $display("press test done");
  endtask : press
  initial
  begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    wt(20);
    check(cmd.haltReq === 1'b1 && lamp === 1'b0);
    check(!$isunknown({cmd, sysInit, lamp}));
    press(1'b0);
    press(1'b1);
    repeat (6) press(1'($random(seed)));
    @(posedge sys_clk) wantRun <= 1'b1;
    wt(20);
    check(cmd.haltReq === 1'b0 && lamp === 1'b1);
    @(posedge sys_clk) hlt <= 1'b1;
    @(posedge sys_clk) hlt <= 1'b0;
    wt(5);
    check(lamp === 1'b0);
    @(posedge sys_clk) blk <= 1'b1;
    wt(5);
    check(lamp === 1'b1);
    @(posedge sys_clk) blk <= 1'b0;
    @(posedge sys_clk) wantRun <= 1'b0;
    wt(20);
    n[0] = 0;
    @(posedge sys_clk) wantRun <= 1'b1;
    repeat (30)
    begin
      wt(1);
      n[0] += cmd.resumePulse;
    end
    check(n[0] === 1 && lamp === 1'b1);
    $display("halt test done");
    results();
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      results();
    end
  end
endmodule : console_halt_init_control_tb
`default_nettype wire
